// >>> serial_flash_erase_protect_cmds_tb_top.sv
// Bench driving the host end's byte port and the device's side inputs.
// Assumes both ends meet through sfep_if; busy counts are shortened.
`timescale 1ns/100ps
module serial_flash_erase_protect_cmds_tb_top;
  localparam int SE = 40;
  localparam int CE = 60;
  localparam int EP = 30;
  logic               sys_clk = 1'b0;
  logic               rstn = 1'b0;
  logic               page_256 = 1'b0;
  logic [15:0][7:0]   spr_bytes = '0;
  logic [15:0]        lock_mask = 16'h0040;
  logic               buf_rd_sel = 1'b0;
  logic [8:0]         buf_rd_addr = 9'h000;
  logic               tx_valid = 1'b0;
  logic [7:0]         tx_data = 8'h00;
  logic               tx_last = 1'b0;
  logic               wp_assert = 1'b0;
  logic [7:0]         buf_rd_data;
  logic               busy;
  logic               prot_enabled;
  logic               op_start;
  logic               op_refused;
  logic               op_buf_sel;
  sfep_pkg::sfep_op_t op_kind;
  logic [11:0]        op_page;
  logic [16:0]        op_erase_mask;
  logic               tx_ready;
  logic               rx_valid;
  logic [7:0]         rx_data;
  logic               frame_active;
  logic [7:0]         rxq[$];
  int                 bad_count = 0;
  int                 checked = 0;
  int                 n_start = 0;
  int                 n_ref = 0;
  int                 s0;
  int                 r0;
  int                 blen = 0;
  logic               se_mode [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [23:0]        se_addr [4] = '{24'h00_1000, 24'h1E_2400, 24'h00_0700, 24'h05_ABCD};
  logic [16:0]        se_mask [4] = '{17'h0_0002, 17'h1_0000, 17'h0_0001, 17'h0_0040};

  sfep_if lk();
  sfep_device #(.SE_CYCLES(SE), .CE_CYCLES(CE), .EP_CYCLES(EP)) sfep_device_i (
    .sys_clk, .rstn, .link(lk), .page_256, .spr_bytes, .lock_mask, .buf_rd_sel,
    .buf_rd_addr, .buf_rd_data, .busy, .prot_enabled, .op_start, .op_kind, .op_page,
    .op_erase_mask, .op_buf_sel, .op_refused);
  sfep_host sfep_host_i (
    .sys_clk, .rstn, .link(lk), .tx_valid, .tx_ready, .tx_data, .tx_last, .wp_assert,
    .rx_valid, .rx_data, .frame_active);
  sfep_monitor sfep_monitor_i (
    .sys_clk, .rstn, .sck(lk.sck), .cs_n(lk.cs_n), .wp_n(lk.wp_n), .busy,
    .prot_enabled, .op_start, .op_refused);

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
    if (op_start === 1'b1)
      n_start <= n_start + 1;
    if (op_refused === 1'b1)
      n_ref <= n_ref + 1;
    if (op_start === 1'b1)
      blen <= 1;
    else if (busy === 1'b1)
      blen <= blen + 1;
  end

  task automatic final_report();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout();
    bad_count++;
    $display("BAD wait expected done seen stuck");
    final_report();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Sends one whole frame, MSB byte first, and lets the device react
  task automatic send(input logic [63:0] v, input int n);
    int t;
    s0 = n_start;
    r0 = n_ref;
    rxq.delete();
    for (int i = 0; i < n; i++)
    begin
      tx_data  <= v[8*(n-1-i) +: 8];
      tx_last  <= (i == n - 1);
      tx_valid <= 1'b1;
      @(posedge sys_clk);
      for (t = 0; tx_ready !== 1'b1 && t < 500; t++)
        @(posedge sys_clk);
      if (t == 500)
        timeout();
    end
    tx_valid <= 1'b0;
    for (t = 0; frame_active !== 1'b0 && t < 500; t++)
      @(posedge sys_clk);
    if (t == 500)
      timeout();
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic expect_op(input sfep_pkg::sfep_op_t k, input logic [16:0] m, input int len);
    int t;
    for (t = 0; busy !== 1'b0 && t < 500; t++)
      @(posedge sys_clk);
    if (t == 500)
      timeout();
    chk("starts", n_start - s0, 1);
    chk("kind", op_kind, k);
    chk("mask", op_erase_mask, m);
    chk("busy_len", blen, len);
  endtask

  task automatic peek(input logic s, input logic [8:0] a, input logic [7:0] e);
    buf_rd_sel  <= s;
    buf_rd_addr <= a;
    repeat (2) @(posedge sys_clk);
    chk("buffer", buf_rd_data, e);
  endtask

  task automatic prog(input logic md, input logic [7:0] op, input logic [23:0] a,
                      input logic [8:0] p0, input logic [11:0] pg, input logic [16:0] m);
    page_256 <= md;
    send({op, a, 16'hA1B2}, 6);
    expect_op(sfep_pkg::SFEP_OP_PROG, m, EP);
    chk("page", op_page, pg);
    chk("buf_sel", op_buf_sel, op[0]);
    peek(op[0], p0, 8'hA1);
    peek(op[0], 9'h000, 8'hB2);
  endtask

  initial
  begin
    spr_bytes[3] <= 8'hFF;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    send(64'h0000_0000_0000_D700, 2);
    chk("status", rxq[1], 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      page_256 <= se_mode[i];
      send({8'h7C, se_addr[i]}, 4);
      expect_op(sfep_pkg::SFEP_OP_SECTOR, se_mask[i], SE);
      chk("page", op_page, se_mode[i] ? se_addr[i][19:8] : se_addr[i][20:9]);
    end
    prog(1'b0, 8'h85, 24'h02_4707, 9'h107, 12'h123, 17'h0_0004);
    prog(1'b1, 8'h82, 24'h00_A0FF, 9'h0FF, 12'h0A0, 17'h0_0002);
    page_256 <= 1'b0;
    send(64'h0000_0000_3D2A_7FA9, 4);
    chk("prot", prot_enabled, 1'b1);
    send(64'h0000_0000_0000_D700, 2);
    chk("status", rxq[1], 8'h82);
    send(64'h0000_00C7_9480_9A55, 5);
    expect_op(sfep_pkg::SFEP_OP_CHIP, 17'h1_FF6F, CE);
    send(64'h0000_0000_7C06_0000, 4);
    chk("refused", n_ref - r0, 1);
    chk("starts", n_start - s0, 0);
    wp_assert <= 1'b1;
    repeat (10) @(posedge sys_clk);
    send(64'h0000_0000_3D2A_7F9A, 4);
    chk("prot", prot_enabled, 1'b1);
    wp_assert <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("prot", prot_enabled, 1'b1);
    send(64'h0000_0000_3D2A_7F00, 4);
    chk("prot", prot_enabled, 1'b1);
    send(64'h0000_0000_3D2A_7F9A, 4);
    chk("prot", prot_enabled, 1'b0);
    wp_assert <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("prot", prot_enabled, 1'b1);
    wp_assert <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("prot", prot_enabled, 1'b0);
    send(64'h0000_0000_7C0A_0000, 4);
    wp_assert <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("busy", busy, 1'b1);
    chk("prot", prot_enabled, 1'b0);
    expect_op(sfep_pkg::SFEP_OP_SECTOR, 17'h0_0040, SE);
    repeat (6) @(posedge sys_clk);
    chk("prot", prot_enabled, 1'b1);
    wp_assert <= 1'b0;
    send(64'h0000_0000_3D2A_7FA9, 4);
    chk("prot", prot_enabled, 1'b1);
    // Mid-run reset stands in for a power cycle
    rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("prot", prot_enabled, 1'b0);
    send(64'h0000_0000_3D2A_7FA9, 4);
    chk("prot", prot_enabled, 1'b1);
    final_report();
  end
endmodule

// >>> sfep_device.sv
// Flash-side command decoder, buffer writer, protection and busy timing.
// Assumes link pins are asynchronous to sys_clk and sampled here.
`timescale 1ns/100ps
module sfep_device #(
  parameter int SE_CYCLES = sfep_pkg::SECTOR_ERASE_CYCLES,
  parameter int CE_CYCLES = sfep_pkg::CHIP_ERASE_CYCLES,
  parameter int EP_CYCLES = sfep_pkg::PAGE_EP_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  sfep_if.device                    link,
  input  wire logic                 page_256,
  input  wire logic [15:0][7:0]     spr_bytes,
  input  wire logic [15:0]          lock_mask,
  input  wire logic                 buf_rd_sel,
  input  wire logic [8:0]           buf_rd_addr,
  output logic      [7:0]           buf_rd_data,
  output logic                      busy,
  output logic                      prot_enabled,
  output logic                      op_start,
  output sfep_pkg::sfep_op_t        op_kind,
  output logic      [11:0]          op_page,
  output logic      [16:0]          op_erase_mask,
  output logic                      op_buf_sel,
  output logic                      op_refused
);
  if (SE_CYCLES < 1 || CE_CYCLES < 1 || EP_CYCLES < 1)
  begin : g_bad_cycles
    $error("sfep_device: operation cycle counts must be at least one");
  end

  // One-hot erase unit of a page: bit0 sector 0a, bit1 sector 0b, bit k+1 sector k
  function automatic logic [16:0] sector_of(input logic [11:0] page);
    logic [16:0] m;
    m = '0;
    if (page[11:8] != 4'h0)
      m[page[11:8] + 5'd1] = 1'b1;
    else if (page[7:3] != 5'h00)
      m[1] = 1'b1;
    else
      m[0] = 1'b1;
    return m;
  endfunction

  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic        sck_d;
  logic        cs_d;
  logic [2:0]  bit_cnt;
  logic [6:0]  shift;
  logic [2:0]  byte_cnt;
  logic [31:0] cmd_bytes;
  logic        cmd_live;
  logic [8:0]  buf_ptr;
  logic [7:0]  out_sh;
  logic        miso_q;
  logic        wp_act;
  logic        sw_prot;
  logic [31:0] timer;
  logic [7:0]  buf_mem [2][sfep_pkg::BUF_BYTES_264];
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        cs_fall;
  logic        sel;
  logic        byte_done;
  logic [7:0]  new_byte;
  logic [7:0]  opcode;
  logic [11:0] page;
  logic [8:0]  buf_size;
  logic [16:0] marked;
  logic [16:0] locked;
  logic [16:0] blocked;
  logic [16:0] target;
  logic [7:0]  status;
  logic        addr_cmd;

  // Pins pass two flops; order is wp_n, mosi, cs_n, sck
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      // Idle pin levels, so no false clock edge follows reset
      sync1 <= 4'hE;
      sync2 <= 4'hE;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sync1 <= {link.wp_n, link.mosi, link.cs_n, link.sck};
      sync2 <= sync1;
      sck_d <= sync2[0];
      cs_d  <= sync2[1];
    end
  end

  assign sel       = !sync2[1];
  assign sck_rise  = sel && sync2[0] && !sck_d;
  assign sck_fall  = sel && !sync2[0] && sck_d;
  assign cs_rise   = sync2[1] && !cs_d;
  assign cs_fall   = !sync2[1] && cs_d;
  assign byte_done = sck_rise && bit_cnt == 3'h7;
  assign new_byte  = {shift, sync2[2]};
  assign opcode    = cmd_bytes[31:24];
  assign page      = page_256 ? cmd_bytes[19:8] : cmd_bytes[20:9];
  assign buf_size  = page_256 ? 9'(sfep_pkg::BUF_BYTES_256) : 9'(sfep_pkg::BUF_BYTES_264);
  assign addr_cmd  = opcode == sfep_pkg::OP_SECTOR_ERASE || opcode == sfep_pkg::OP_PROG_BUF1
                     || opcode == sfep_pkg::OP_PROG_BUF2;

  // Protection bytes: FF marks sectors 1-15, bit pairs mark 0a and 0b
  always_comb begin
    marked[0] = spr_bytes[0][sfep_pkg::SPR_0A_HI -: 2] == sfep_pkg::SPR_ZERO_PROT;
    marked[1] = spr_bytes[0][sfep_pkg::SPR_0B_HI -: 2] == sfep_pkg::SPR_ZERO_PROT;
    locked[0] = lock_mask[0];
    locked[1] = lock_mask[0];
    for (int k = 1; k < sfep_pkg::SECTORS; k++) begin
      marked[k + 1] = spr_bytes[k] == sfep_pkg::SPR_PROTECTED;
      locked[k + 1] = lock_mask[k];
    end
  end

  assign prot_enabled = sw_prot || wp_act;
  assign blocked = (prot_enabled ? marked : 17'h0_0000) | locked;
  assign target  = sector_of(page);
  assign busy    = timer != 32'h0000_0000;
  always_comb
  begin
    status                             = 8'h00;
    status[sfep_pkg::STAT_READY_BIT]   = !busy;
    status[sfep_pkg::STAT_PROT_BIT]    = prot_enabled;
    status[sfep_pkg::STAT_MODE_BIT]    = page_256;
  end
  assign link.miso = miso_q;

  // Bit and byte framing; bytes past the fourth are not stored, and the count stops at five
  always_ff @(posedge sys_clk) begin
    if (!rstn || !sel) begin
      bit_cnt   <= 3'h0;
      shift     <= 7'h00;
      byte_cnt  <= 3'h0;
      cmd_bytes <= 32'h0000_0000;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= new_byte[6:0];
      if (byte_done && byte_cnt < 3'h4) begin
        cmd_bytes <= {cmd_bytes[23:0], new_byte};
        byte_cnt  <= byte_cnt + 3'h1;
      end else if (byte_done && byte_cnt == 3'h4) begin
        byte_cnt <= 3'h5;
      end
    end
  end

  // Erase, program and protect frames are only acted on if they began while the array was idle
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      cmd_live <= 1'b0;
    else if (cs_fall)
      cmd_live <= !busy;
  end

  // Data bytes after the address go into the chosen buffer, wrapping
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      buf_ptr <= 9'h000;
    end else if (byte_done && cmd_live && byte_cnt == 3'h3) begin
      buf_ptr <= page_256 ? {1'b0, new_byte} : {cmd_bytes[0], new_byte};
    end else if (byte_done && cmd_live && byte_cnt >= 3'h4
                 && (opcode == sfep_pkg::OP_PROG_BUF1 || opcode == sfep_pkg::OP_PROG_BUF2)) begin
      buf_ptr <= (buf_ptr + 9'h001 >= buf_size) ? 9'h000 : buf_ptr + 9'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (byte_done && cmd_live && byte_cnt >= 3'h4
        && (opcode == sfep_pkg::OP_PROG_BUF1 || opcode == sfep_pkg::OP_PROG_BUF2))
      buf_mem[opcode == sfep_pkg::OP_PROG_BUF2][buf_ptr] <= new_byte;
    buf_rd_data <= buf_mem[buf_rd_sel][buf_rd_addr];
  end

  // Status byte shifted out on falling edges after the status opcode
  always_ff @(posedge sys_clk) begin
    if (!rstn || !sel) begin
      out_sh <= 8'h00;
      miso_q <= 1'b0;
    end else if (byte_done && (byte_cnt == 3'h0 ? new_byte : opcode) == sfep_pkg::OP_STATUS) begin
      out_sh <= status;
    end else if (sck_fall) begin
      miso_q <= out_sh[7];
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  // Hardware protect follows the pin only while no erase or program is running
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      wp_act <= 1'b0;
    else if (!busy)
      wp_act <= !sync2[3];
  end

  // Software protect is volatile and changes only at select release
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sw_prot <= 1'b0;
    end else if (cs_rise && cmd_live && bit_cnt == 3'h0 && byte_cnt == 3'h4) begin
      if (cmd_bytes == sfep_pkg::SEQ_PROT_ENABLE)
        sw_prot <= 1'b1;
      else if (cmd_bytes == sfep_pkg::SEQ_PROT_DISABLE && !wp_act)
        sw_prot <= 1'b0;
    end
  end

  // Array operation launch on select release, then self-timed busy
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timer         <= 32'h0000_0000;
      op_start      <= 1'b0;
      op_refused    <= 1'b0;
      op_kind       <= sfep_pkg::SFEP_OP_NONE;
      op_page       <= 12'h000;
      op_erase_mask <= 17'h0_0000;
      op_buf_sel    <= 1'b0;
    end else begin
      op_start   <= 1'b0;
      op_refused <= 1'b0;
      if (busy)
        timer <= timer - 32'h0000_0001;
      if (cs_rise && cmd_live && bit_cnt == 3'h0 && byte_cnt >= 3'h4) begin
        if (addr_cmd && (target & blocked) != 17'h0_0000) begin
          op_refused <= 1'b1;
        end else if (addr_cmd) begin
          op_start      <= 1'b1;
          op_page       <= page;
          op_erase_mask <= target;
          op_buf_sel    <= opcode == sfep_pkg::OP_PROG_BUF2;
          if (opcode == sfep_pkg::OP_SECTOR_ERASE) begin
            op_kind <= sfep_pkg::SFEP_OP_SECTOR;
            timer   <= 32'(SE_CYCLES);
          end else begin
            op_kind <= sfep_pkg::SFEP_OP_PROG;
            timer   <= 32'(EP_CYCLES);
          end
        end else if (cmd_bytes == sfep_pkg::SEQ_CHIP_ERASE) begin
          op_start      <= 1'b1;
          op_kind       <= sfep_pkg::SFEP_OP_CHIP;
          op_erase_mask <= ~blocked;
          timer         <= 32'(CE_CYCLES);
        end
      end
    end
  end
endmodule

// >>> sfep_host.sv
// Bus-master end: sends user bytes on the link and returns read bytes.
// Assumes the device samples on rising link clock edges.
`timescale 1ns/100ps
module sfep_host #(
  parameter int HALF_CYCLES = sfep_pkg::SCK_HALF_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  sfep_if.host             link,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  input  wire logic        wp_assert,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             frame_active
);
  if (HALF_CYCLES < 8 || HALF_CYCLES > 255)
  begin : g_bad_half
    $error("sfep_host: HALF_CYCLES must lie in 8..255");
  end

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_NEXT, H_HOLD, H_GAP} sfep_hstate_t;

  sfep_hstate_t state;
  logic [7:0]   cnt;
  logic [2:0]   bit_idx;
  logic [7:0]   tx_sh;
  logic [7:0]   rx_sh;
  logic         last_q;
  logic         sck_q;
  logic         cs_q;
  logic         mosi_q;
  logic         wp_q;
  logic         miso_s1;
  logic         miso_s2;
  logic         half_done;

  assign half_done    = cnt == 8'(HALF_CYCLES - 1);
  assign tx_ready     = state == H_IDLE || state == H_NEXT;
  assign frame_active = !cs_q;
  assign link.sck     = sck_q;
  assign link.cs_n    = cs_q;
  assign link.mosi    = mosi_q;
  assign link.wp_n    = wp_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      wp_q    <= 1'b1;
    end else begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
      wp_q    <= !wp_assert;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn || state == H_IDLE || state == H_NEXT || half_done)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h01;
  end

  // Divided link clock; select drops only around a run of bytes
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state    <= H_IDLE;
      bit_idx  <= 3'h0;
      tx_sh    <= 8'h00;
      rx_sh    <= 8'h00;
      last_q   <= 1'b0;
      sck_q    <= 1'b0;
      cs_q     <= 1'b1;
      mosi_q   <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      unique case (state)
        H_IDLE, H_NEXT:
          if (tx_valid) begin
            tx_sh   <= {tx_data[6:0], 1'b0};
            mosi_q  <= tx_data[7];
            last_q  <= tx_last;
            bit_idx <= 3'h0;
            cs_q    <= 1'b0;
            state   <= state == H_IDLE ? H_SETUP : H_LOW;
          end
        H_SETUP:
          if (half_done)
            state <= H_LOW;
        H_LOW:
          if (half_done) begin
            sck_q <= 1'b1;
            rx_sh <= {rx_sh[6:0], miso_s2};
            state <= H_HIGH;
          end
        H_HIGH:
          if (half_done) begin
            sck_q   <= 1'b0;
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) begin
              rx_valid <= 1'b1;
              rx_data  <= rx_sh;
              state    <= last_q ? H_HOLD : H_NEXT;
            end else begin
              mosi_q <= tx_sh[7];
              tx_sh  <= {tx_sh[6:0], 1'b0};
              state  <= H_LOW;
            end
          end
        H_HOLD:
          if (half_done) begin
            cs_q  <= 1'b1;
            state <= H_GAP;
          end
        H_GAP:
          if (half_done)
            state <= H_IDLE;
      endcase
    end
  end
endmodule

// >>> sfep_if.sv
// Serial link between the flash command sequencer and its bus master.
// Assumes the host drives clock, select, data-in and write-protect.
`timescale 1ns/100ps
interface sfep_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic wp_n;
  modport device (input sck, input cs_n, input mosi, input wp_n, output miso);
  modport host (output sck, output cs_n, output mosi, output wp_n, input miso);
endinterface

// >>> sfep_monitor.sv
// Checker on the link pins and the device's launch, busy and protect outputs.
// Assumes one sys_clk domain with synchronous active-low rstn.
`timescale 1ns/100ps
module sfep_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic busy,
  input wire logic prot_enabled,
  input wire logic op_start,
  input wire logic op_refused
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock high while deselected");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap shorter than half period");
  a_launch_busy: assert property (op_start |-> busy)
    else $error("launch without busy");
  a_busy_cause: assert property ($rose(busy) |-> op_start)
    else $error("busy rose without launch");
  a_launch_after_release: assert property (op_start |-> $past(cs_n, 3) && !$past(cs_n, 4))
    else $error("launch not tied to select release");
  a_launch_when_idle: assert property (op_start |-> !$past(busy))
    else $error("launch while busy");
  a_wp_enables: assert property ((!wp_n && !busy) [*5] |-> prot_enabled)
    else $error("write protect did not enable protection");
  a_wp_waits_busy: assert property (busy && $past(busy) |-> $stable(prot_enabled))
    else $error("protection changed during array operation");
  a_refuse_quiet: assert property (op_refused |-> !busy && !op_start)
    else $error("refused operation still launched");
endmodule

// >>> sfep_pkg.sv
// Constants shared by both ends of the serial flash erase/protect link.
// Assumes a 250 MHz system clock on each end; no other dependencies.
// Overview of operation
// - 264-mode 0a/0b erase: 7C, page bits 11..3
// - 264-mode sector 1-15 erase: 7C, bits 11..8
// - 256-mode 0a/0b erase: 7C, address 19..11
// - 256-mode sector 1-15 erase: 7C, address 19..16
// - Sixteen sectors, one erased per command
// - Any page in sector selects it; busy
// - Chip erase C7 94 80 9A; extras ignored
// - Chip erase starts at select release, busy
// - Chip erase skips protected or locked sectors
// - Write-protect waits for erase to finish
// - 264-mode program via buffer 82/85, addressing
// - 256-mode program via buffer 82/85, addressing
// - Data bytes fill buffer, wrapping to zero
// - Select release erases page, programs buffer
// - 3D 2A 7F A9 enables software protection
// - 3D 2A 7F 9A disables software protection
// - Disable ignored while write-protect asserted
// - Protected sectors refuse program and erase
// - Status byte shows protection enabled state
// - Software protection cleared at reset
// - Host reissues enable after every power-up
// - Sixteen protection bytes, FF protects, 00 not
// - Write-protect alone enables protection
package sfep_pkg;
  localparam int          CLK_PERIOD_PS       = 4000;
  localparam int          SCK_HALF_CYCLES     = 8;
  localparam int          SECTOR_ERASE_MAX_TIME_US   = 1000;
  localparam int          CHIP_ERASE_TIME_US         = 10000;
  localparam int          PAGE_ERASE_PROGRAM_TIME_US = 20;
  // Cycles per microsecond first, so the products stay inside 32 bits
  localparam int          SECTOR_ERASE_CYCLES = SECTOR_ERASE_MAX_TIME_US
                                                * (1000000 / CLK_PERIOD_PS);
  localparam int          CHIP_ERASE_CYCLES   = CHIP_ERASE_TIME_US
                                                * (1000000 / CLK_PERIOD_PS);
  localparam int          PAGE_EP_CYCLES      = PAGE_ERASE_PROGRAM_TIME_US
                                                * (1000000 / CLK_PERIOD_PS);
  localparam logic [7:0]  OP_SECTOR_ERASE     = 8'h7C;
  localparam logic [7:0]  OP_PROG_BUF1        = 8'h82;
  localparam logic [7:0]  OP_PROG_BUF2        = 8'h85;
  localparam logic [7:0]  OP_STATUS           = 8'hD7;
  localparam logic [31:0] SEQ_CHIP_ERASE      = 32'hC794_809A;
  localparam logic [31:0] SEQ_PROT_ENABLE     = 32'h3D2A_7FA9;
  localparam logic [31:0] SEQ_PROT_DISABLE    = 32'h3D2A_7F9A;
  localparam logic [7:0]  SPR_PROTECTED       = 8'hFF;
  localparam logic [1:0]  SPR_ZERO_PROT       = 2'h3;
  localparam int          SPR_0A_HI           = 7;
  localparam int          SPR_0B_HI           = 5;
  localparam int          SECTORS             = 16;
  localparam int          ERASE_UNITS         = 17;
  localparam int          BUF_BYTES_264       = 264;
  localparam int          BUF_BYTES_256       = 256;
  localparam int          STAT_READY_BIT      = 7;
  localparam int          STAT_PROT_BIT       = 1;
  localparam int          STAT_MODE_BIT       = 0;
  typedef enum logic [1:0] {SFEP_OP_NONE, SFEP_OP_SECTOR, SFEP_OP_CHIP, SFEP_OP_PROG} sfep_op_t;
endpackage
